//--- core/uprd_map.vh
// Constants for the USB packet register access block
`ifndef UPRD_MAP_VH
`define UPRD_MAP_VH

// ----------------------------------------------------------------
// Packet framing
// ----------------------------------------------------------------
`define UPRD_HDR_LAST      3'h7
`define UPRD_HDR_CNT_RST   3'h0
`define UPRD_WR_BIT        31
`define UPRD_MOD_MSB       30
`define UPRD_MOD_LSB       24
`define UPRD_SEL_MSB       23

// ----------------------------------------------------------------
// Module map
// ----------------------------------------------------------------
`define UPRD_MOD_CTL       7'h01
`define UPRD_MOD_NVM       7'h10
`define UPRD_CTL_REG_W     5
`define UPRD_CTL_SEL_LSB   5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define UPRD_RST_ADDR      32'h0000_0000
`define UPRD_RST_LEN       24'h00_0000
`define UPRD_RST_WORD      16'h0000
`define UPRD_RST_BYTE      8'h00
`define UPRD_RST_SW        8'h00

// ----------------------------------------------------------------
// Write data buffer and switch positions
// ----------------------------------------------------------------
`define UPRD_FIFO_WIDTH    16
`define UPRD_FIFO_DEPTH    32
`define UPRD_FIFO_AW       5
`define UPRD_SW_STACK      6
`define UPRD_SW_SLAVE      7

`endif

//--- core/uprd_fifo.v
// Write payload FIFO between packet parser and module access port
`timescale 1ns/1ps
module uprd_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clk_i,
  input  wire             rst_n_i,
  input  wire             in_valid_i,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             in_ready_o,
  output wire             almost_full_o,
  output wire             out_valid_o,
  output wire [WIDTH-1:0] out_data_o,
  input  wire             out_ready_i
);

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  localparam [31:0] DEPTH_W  = DEPTH;          // Depth at full integer width
  localparam [31:0] AF_W     = DEPTH - 1;      // One below full at integer width
  localparam [AW:0] LVL_FULL = DEPTH_W[AW:0];  // Count when full
  localparam [AW:0] LVL_AF   = AF_W[AW:0];     // Count one below full

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];       // Word storage
  reg [AW-1:0]    wr_ptr_q;                // Next slot to fill
  reg [AW-1:0]    rd_ptr_q;                // Next slot to drain
  reg [AW:0]      count_q;                 // Words held

  wire push = in_valid_i & in_ready_o;     // Word accepted
  wire pop  = out_valid_o & out_ready_i;   // Word drained

  assign in_ready_o    = (count_q != LVL_FULL);
  assign almost_full_o = (count_q >= LVL_AF);
  assign out_valid_o   = (count_q != {(AW+1){1'b0}});
  assign out_data_o    = mem_q[rd_ptr_q];

  // Pointer and level update
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push & ~pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop & ~push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

  // Data write, no reset needed on storage
  always @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

endmodule

//--- core/uprd_cfg.v
// Board configuration switch sampler and decoder
`timescale 1ns/1ps
`include "uprd_map.vh"
module uprd_cfg (
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire [7:0] board_config_switch_i,
  output reg  [7:0] cfg_sw_o,
  output reg        cfg_stacked_o,
  output reg        cfg_master_o,
  output reg        cfg_slave_o
);

  // ----------------------------------------------------------------
  // Sample and decode
  // ----------------------------------------------------------------
  // A high bit means the position is up
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_sw_o      <= `UPRD_RST_SW;
      cfg_stacked_o <= 1'b0;
      cfg_master_o  <= 1'b0;
      cfg_slave_o   <= 1'b0;
    end else begin
      cfg_sw_o      <= board_config_switch_i;
      // Seventh up means stacked, eighth then picks the role
      cfg_stacked_o <= board_config_switch_i[`UPRD_SW_STACK];
      cfg_master_o  <= board_config_switch_i[`UPRD_SW_STACK] &
                       ~board_config_switch_i[`UPRD_SW_SLAVE];
      cfg_slave_o   <= board_config_switch_i[`UPRD_SW_STACK] &
                       board_config_switch_i[`UPRD_SW_SLAVE];
    end
  end

endmodule

//--- core/uprd_top.v
// USB packet parser that turns host packets into module register accesses
//
// How it works
// - Packet: zero byte, address, length, payload
// - Address top bit writes, 30:24 module
// - Lower address bits select module register
// - Length counts 16-bit payload words
// - Consume two bytes per word, then next
// - Module one reaches chain controller registers
// - Only controller implemented, sixteen is not
// - Both reads and writes are supported
// - Configuration switch sampled as plain inputs
// - Switch seven stack, eight master/slave
// - Read returns two bytes per word
// - Bytes move over synchronous FIFO bridge
// - Fields and words sent high byte first
`timescale 1ns/1ps
`include "uprd_map.vh"
module uprd_top (
  input  wire        clk_i,
  input  wire        rst_n_i,
  // USB bridge FIFO side
  input  wire        usb_rxf_n_i,
  input  wire        usb_txe_n_i,
  input  wire [7:0]  usb_data_i,
  output reg  [7:0]  usb_data_o,
  output reg         usb_data_oe_o,
  output reg         usb_oe_n_o,
  output reg         usb_rd_n_o,
  output reg         usb_wr_n_o,
  // Chain controller access port
  output reg         ctl_strobe_o,
  output reg         ctl_we_o,
  output reg  [4:0]  ctl_reg_o,
  output reg  [15:0] ctl_wdata_o,
  input  wire [15:0] ctl_rdata_i,
  input  wire        ctl_rdy_i,
  // Board configuration
  input  wire [7:0]  board_config_switch_i,
  output wire [7:0]  cfg_sw_o,
  output wire        cfg_stacked_o,
  output wire        cfg_master_o,
  output wire        cfg_slave_o
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [2:0] S_HDR   = 3'h0;  // Collect header bytes
  localparam [2:0] S_WPAY  = 3'h1;  // Collect write payload
  localparam [2:0] S_WDONE = 3'h2;  // Wait for writes to drain
  localparam [2:0] S_RREQ  = 3'h3;  // Issue one read
  localparam [2:0] S_RWAIT = 3'h4;  // Wait for read data
  localparam [2:0] S_TXH   = 3'h5;  // Send high byte
  localparam [2:0] S_TXL   = 3'h6;  // Send low byte

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg  [2:0]  state_q, state_d;     // Parser state
  reg  [2:0]  hdr_cnt_q, hdr_cnt_d; // Header byte index
  reg  [55:0] hdr_q, hdr_d;         // Header bytes seen so far
  reg  [31:0] addr_q, addr_d;       // Current read address
  reg  [23:0] len_q, len_d;         // Words left in packet
  reg  [7:0]  hi_q, hi_d;           // Held high payload byte
  reg         hi_have_q, hi_have_d; // High byte held
  reg  [15:0] word_q, word_d;       // Read word being sent
  reg  [31:0] waddr_q;              // Current write address
  reg  [7:0]  txd_d;                // Next outgoing byte
  reg         push;                 // Payload word complete
  reg         rd_issue;             // Start a controller read
  reg         load_w;               // Write header accepted
  reg         oe_n_d;               // Next bridge output enable
  reg         rd_n_d;               // Next bridge read strobe
  reg         wr_n_d;               // Next bridge write strobe
  reg         want_rx;              // Parser can take a byte

  wire        take_rx = ~usb_rd_n_o & ~usb_rxf_n_i; // Byte received
  wire        take_tx = ~usb_wr_n_o & ~usb_txe_n_i; // Byte sent
  wire        fifo_ready;            // Buffer has room
  wire        fifo_afull;            // Buffer full or one slot from full
  wire        fifo_valid;            // Buffer holds a word
  wire [15:0] fifo_data;             // Oldest buffered word
  wire        pop;                   // Drain one buffered word
  wire        wr_issue;              // Start a controller write

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // True when the address lands inside the controller window
  function hit;
    input [31:0] a;
    begin
      hit = (a[`UPRD_MOD_MSB:`UPRD_MOD_LSB] == `UPRD_MOD_CTL) &&
            (a[`UPRD_SEL_MSB:`UPRD_CTL_SEL_LSB] == 19'h0_0000);
    end
  endfunction

  // ----------------------------------------------------------------
  // Parser next state
  // ----------------------------------------------------------------
  // One byte at most per cycle; header, then payload or reply
  always @* begin
    state_d   = state_q;
    hdr_cnt_d = hdr_cnt_q;
    hdr_d     = hdr_q;
    addr_d    = addr_q;
    len_d     = len_q;
    hi_d      = hi_q;
    hi_have_d = hi_have_q;
    word_d    = word_q;
    txd_d     = usb_data_o;
    push      = 1'b0;
    rd_issue  = 1'b0;
    load_w    = 1'b0;
    case (state_q)
      S_HDR: begin
        if (take_rx) begin
          hdr_d     = {hdr_q[47:0], usb_data_i};
          hdr_cnt_d = hdr_cnt_q + 3'h1;
          if (hdr_cnt_q == `UPRD_HDR_LAST) begin
            hdr_cnt_d = `UPRD_HDR_CNT_RST;
            addr_d    = hdr_q[47:16];
            len_d     = {hdr_q[15:0], usb_data_i};
            hi_have_d = 1'b0;
            if (hdr_q[47]) begin
              // Write: payload follows
              load_w  = 1'b1;
              state_d = (len_d == `UPRD_RST_LEN) ? S_WDONE : S_WPAY;
            end else begin
              // Read: reply with data words
              state_d = (len_d == `UPRD_RST_LEN) ? S_HDR : S_RREQ;
            end
          end
        end
      end
      S_WPAY: begin
        if (take_rx) begin
          if (!hi_have_q) begin
            hi_d      = usb_data_i;
            hi_have_d = 1'b1;
          end else begin
            hi_have_d = 1'b0;
            push      = 1'b1;
            len_d     = len_q - 24'h00_0001;
            if (len_q == 24'h00_0001) begin
              state_d = S_WDONE;
            end
          end
        end
      end
      S_WDONE: begin
        // Next packet only once every buffered write has been drained
        if (!fifo_valid && !ctl_strobe_o) begin
          state_d = S_HDR;
        end
      end
      S_RREQ: begin
        if (!hit(addr_q)) begin
          // Address outside the controller window answers with zero words
          word_d  = `UPRD_RST_WORD;
          txd_d   = `UPRD_RST_BYTE;
          state_d = S_TXH;
        end else if (ctl_rdy_i && !ctl_strobe_o) begin
          rd_issue = 1'b1;
          state_d  = S_RWAIT;
        end
      end
      S_RWAIT: begin
        // Data is stable once ready returns high
        if (!ctl_strobe_o && ctl_rdy_i) begin
          word_d  = ctl_rdata_i;
          txd_d   = ctl_rdata_i[15:8];
          state_d = S_TXH;
        end
      end
      S_TXH: begin
        if (take_tx) begin
          txd_d   = word_q[7:0];
          state_d = S_TXL;
        end
      end
      S_TXL: begin
        if (take_tx) begin
          len_d  = len_q - 24'h00_0001;
          addr_d = addr_q + 32'h0000_0001;
          if (len_q == 24'h00_0001) begin
            state_d = S_HDR;
          end else begin
            state_d = S_RREQ;
          end
        end
      end
      default: begin
        state_d = S_HDR;
      end
    endcase
    // Bridge strobes follow the next state so no byte is dropped
    oe_n_d  = ~((state_d == S_HDR) || (state_d == S_WPAY));
    want_rx = (state_d == S_HDR) ||
              ((state_d == S_WPAY) && !fifo_afull && fifo_ready);
    rd_n_d  = ~(want_rx & ~usb_oe_n_o & ~oe_n_d);
    wr_n_d  = ~((state_d == S_TXH) || (state_d == S_TXL));
  end

  // ----------------------------------------------------------------
  // Parser registers
  // ----------------------------------------------------------------
  // State, counters and bridge pins
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q       <= S_HDR;
      hdr_cnt_q     <= `UPRD_HDR_CNT_RST;
      hdr_q         <= 56'h00_0000_0000_0000;
      addr_q        <= `UPRD_RST_ADDR;
      len_q         <= `UPRD_RST_LEN;
      hi_q          <= `UPRD_RST_BYTE;
      hi_have_q     <= 1'b0;
      word_q        <= `UPRD_RST_WORD;
      usb_data_o    <= `UPRD_RST_BYTE;
      usb_data_oe_o <= 1'b0;
      usb_oe_n_o    <= 1'b1;
      usb_rd_n_o    <= 1'b1;
      usb_wr_n_o    <= 1'b1;
    end else begin
      state_q       <= state_d;
      hdr_cnt_q     <= hdr_cnt_d;
      hdr_q         <= hdr_d;
      addr_q        <= addr_d;
      len_q         <= len_d;
      hi_q          <= hi_d;
      hi_have_q     <= hi_have_d;
      word_q        <= word_d;
      usb_data_o    <= txd_d;
      usb_data_oe_o <= ~wr_n_d;
      usb_oe_n_o    <= oe_n_d;
      usb_rd_n_o    <= rd_n_d;
      usb_wr_n_o    <= wr_n_d;
    end
  end

  // ----------------------------------------------------------------
  // Write payload buffer
  // ----------------------------------------------------------------
  uprd_fifo #(
    .WIDTH (`UPRD_FIFO_WIDTH),
    .DEPTH (`UPRD_FIFO_DEPTH),
    .AW    (`UPRD_FIFO_AW)
  ) u_fifo (
    .clk_i         (clk_i),
    .rst_n_i       (rst_n_i),
    .in_valid_i    (push),
    .in_data_i     ({hi_q, usb_data_i}),
    .in_ready_o    (fifo_ready),
    .almost_full_o (fifo_afull),
    .out_valid_o   (fifo_valid),
    .out_data_o    (fifo_data),
    .out_ready_i   (pop)
  );

  // ----------------------------------------------------------------
  // Module access port
  // ----------------------------------------------------------------
  // Drain one word whenever the controller is ready and idle
  assign pop      = fifo_valid & ctl_rdy_i & ~ctl_strobe_o;
  assign wr_issue = pop & hit(waddr_q);

  // Write address tracks drained words, misses are simply discarded
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      waddr_q <= `UPRD_RST_ADDR;
    end else if (load_w) begin
      waddr_q <= hdr_q[47:16];
    end else if (pop) begin
      waddr_q <= waddr_q + 32'h0000_0001;
    end
  end

  // One-cycle strobe with direction, register and data
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl_strobe_o <= 1'b0;
      ctl_we_o     <= 1'b0;
      ctl_reg_o    <= 5'h00;
      ctl_wdata_o  <= `UPRD_RST_WORD;
    end else begin
      ctl_strobe_o <= rd_issue | wr_issue;
      ctl_we_o     <= wr_issue;
      if (wr_issue) begin
        ctl_reg_o   <= waddr_q[`UPRD_CTL_REG_W-1:0];
        ctl_wdata_o <= fifo_data;
      end else if (rd_issue) begin
        ctl_reg_o <= addr_q[`UPRD_CTL_REG_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Board configuration switch
  // ----------------------------------------------------------------
  uprd_cfg u_cfg (
    .clk_i                 (clk_i),
    .rst_n_i               (rst_n_i),
    .board_config_switch_i (board_config_switch_i),
    .cfg_sw_o              (cfg_sw_o),
    .cfg_stacked_o         (cfg_stacked_o),
    .cfg_master_o          (cfg_master_o),
    .cfg_slave_o           (cfg_slave_o)
  );

endmodule

//--- tb/uprd_sva.sv
// Assertion checker for the USB packet register access block
`timescale 1ns/1ps
module uprd_sva (
  input wire       clk_i,
  input wire       rst_n_i,
  input wire       usb_txe_n_i,
  input wire [7:0] usb_data_o,
  input wire       usb_data_oe_o,
  input wire       usb_oe_n_o,
  input wire       usb_rd_n_o,
  input wire       usb_wr_n_o,
  input wire       ctl_strobe_o,
  input wire       ctl_rdy_i,
  input wire [7:0] board_config_switch_i,
  input wire [7:0] cfg_sw_o,
  input wire       cfg_stacked_o,
  input wire       cfg_master_o,
  input wire       cfg_slave_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Never read and write the bridge at once
  rx_tx_excl_a: assert property (usb_rd_n_o || usb_wr_n_o)
    else $error("read and write strobes low together");
  // Our data pins stay off while the bridge drives
  pin_drive_a: assert property (usb_data_oe_o |-> usb_oe_n_o)
    else $error("data driven while bridge output enabled");
  // A write strobe always comes with driven data
  wr_drive_a: assert property (!usb_wr_n_o |-> usb_data_oe_o)
    else $error("write strobe without driven data");
  // Reading needs the bridge output enabled
  rd_enable_a: assert property (!usb_rd_n_o |-> !usb_oe_n_o)
    else $error("read strobe with bridge output off");
  // A refused byte stays put until taken
  tx_hold_a: assert property ((!usb_wr_n_o && usb_txe_n_i)
    |=> (!usb_wr_n_o && $stable(usb_data_o)))
    else $error("tx byte changed before taken");
  // Controller strobe is one cycle wide
  strobe_pulse_a: assert property (ctl_strobe_o |=> !ctl_strobe_o)
    else $error("controller strobe longer than one cycle");
  // Strobe only towards a ready controller
  strobe_ready_a: assert property ($rose(ctl_strobe_o) |-> $past(ctl_rdy_i))
    else $error("controller strobe while not ready");
  // Switch copied with one cycle latency
  sw_sample_a: assert property ($past(rst_n_i)
    |-> cfg_sw_o == $past(board_config_switch_i))
    else $error("switch copy wrong");
  // Stack and role decode of positions seven and eight
  role_decode_a: assert property (cfg_stacked_o == cfg_sw_o[6]
    && cfg_master_o == (cfg_sw_o[6] && !cfg_sw_o[7])
    && cfg_slave_o == (cfg_sw_o[6] && cfg_sw_o[7]))
    else $error("board role decode wrong");
endmodule

bind uprd_top uprd_sva u_sva (
  .clk_i                (clk_i),
  .rst_n_i              (rst_n_i),
  .usb_txe_n_i          (usb_txe_n_i),
  .usb_data_o           (usb_data_o),
  .usb_data_oe_o        (usb_data_oe_o),
  .usb_oe_n_o           (usb_oe_n_o),
  .usb_rd_n_o           (usb_rd_n_o),
  .usb_wr_n_o           (usb_wr_n_o),
  .ctl_strobe_o         (ctl_strobe_o),
  .ctl_rdy_i            (ctl_rdy_i),
  .board_config_switch_i(board_config_switch_i),
  .cfg_sw_o             (cfg_sw_o),
  .cfg_stacked_o        (cfg_stacked_o),
  .cfg_master_o         (cfg_master_o),
  .cfg_slave_o          (cfg_slave_o)
);

//--- tb/uprd_bridge_model.sv
// Behavioural model of the host behind a synchronous USB FIFO bridge
`timescale 1ns/1ps
module uprd_bridge_model (
  input  wire        clk_i,
  input  wire        usb_rd_n_i,
  input  wire        usb_wr_n_i,
  input  wire [7:0]  usb_data_i,
  input  wire        slow_i,
  output logic       usb_rxf_n_o,
  output logic       usb_txe_n_o,
  output logic [7:0] usb_data_o
);
  logic [7:0] rxq[$];        // Host bytes still to send
  logic [7:0] txq[$];        // Bytes returned to the host
  logic [7:0] last_b = 8'h00; // Last byte handed over
  logic [1:0] cnt_q = 2'h0;  // Stall pattern counter

  initial begin
    usb_rxf_n_o = 1'b1;
    usb_txe_n_o = 1'b0;
    usb_data_o  = 8'hff;
  end

  // Hand bytes over in queue order, collect replies
  always @(posedge clk_i) begin
    if (!usb_rd_n_i && !usb_rxf_n_o)
      last_b = rxq.pop_front();
    if (!usb_wr_n_i && !usb_txe_n_o)
      txq.push_back(usb_data_i);
    cnt_q = cnt_q + 2'h1;
    #1;
    usb_rxf_n_o = (rxq.size() == 0);
    // Idle data lines show no stale byte
    usb_data_o  = usb_rxf_n_o ? ~last_b : rxq[0];
    usb_txe_n_o = slow_i & cnt_q[1];
  end
endmodule

//--- tb/uprd_top_tb.sv
// Self-checking bench for the USB packet register access block
`timescale 1ns/1ps
module uprd_top_tb;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        slow = 1'b0;
  logic        usb_rxf_n_i, usb_txe_n_i;
  logic [7:0]  usb_data_i, usb_data_o;
  logic        usb_data_oe_o, usb_oe_n_o, usb_rd_n_o, usb_wr_n_o;
  logic        ctl_strobe_o, ctl_we_o;
  logic [4:0]  ctl_reg_o;
  logic [15:0] ctl_wdata_o;
  logic [15:0] ctl_rdata_i = 16'h0000;
  logic        ctl_rdy_i = 1'b1;
  logic [7:0]  board_config_switch_i = 8'h00;
  logic [7:0]  cfg_sw_o;
  logic        cfg_stacked_o, cfg_master_o, cfg_slave_o;
  logic [21:0] accq[$]; // Controller accesses seen
  int          fail_count = 0;
  int          samples_checked = 0;

  always #20 clk_i = ~clk_i;

  uprd_top uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .usb_rxf_n_i(usb_rxf_n_i),
    .usb_txe_n_i(usb_txe_n_i), .usb_data_i(usb_data_i), .usb_data_o(usb_data_o),
    .usb_data_oe_o(usb_data_oe_o), .usb_oe_n_o(usb_oe_n_o),
    .usb_rd_n_o(usb_rd_n_o), .usb_wr_n_o(usb_wr_n_o),
    .ctl_strobe_o(ctl_strobe_o), .ctl_we_o(ctl_we_o), .ctl_reg_o(ctl_reg_o),
    .ctl_wdata_o(ctl_wdata_o), .ctl_rdata_i(ctl_rdata_i), .ctl_rdy_i(ctl_rdy_i),
    .board_config_switch_i(board_config_switch_i), .cfg_sw_o(cfg_sw_o),
    .cfg_stacked_o(cfg_stacked_o), .cfg_master_o(cfg_master_o),
    .cfg_slave_o(cfg_slave_o));

  uprd_bridge_model u_br (
    .clk_i(clk_i), .usb_rd_n_i(usb_rd_n_o), .usb_wr_n_i(usb_wr_n_o),
    .usb_data_i(usb_data_o), .slow_i(slow), .usb_rxf_n_o(usb_rxf_n_i),
    .usb_txe_n_o(usb_txe_n_i), .usb_data_o(usb_data_i));

  // Controller stand-in: busy for one cycle after each strobe
  always @(posedge clk_i) begin
    if (ctl_strobe_o) begin
      accq.push_back({ctl_we_o, ctl_reg_o, ctl_wdata_o});
      #1 ctl_rdy_i = 1'b0;
      ctl_rdata_i = {8'hc3, 3'h0, ctl_reg_o};
      @(posedge clk_i) #1 ctl_rdy_i = 1'b1;
    end
  end

  task automatic check(input string what, input logic [23:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Queue a host packet and clear old results
  task automatic send(input logic [7:0] b[$]);
    u_br.txq.delete();
    accq.delete();
    foreach (b[i]) u_br.rxq.push_back(b[i]);
  endtask

  // Wait for replies and accesses, then let stray ones show
  task automatic run(input int ntx, input int nacc);
    for (int i = 0; i < 800; i++) begin
      if (u_br.txq.size() >= ntx && accq.size() >= nacc && u_br.rxq.size() == 0)
        break;
      @(posedge clk_i);
    end
    repeat (30) @(posedge clk_i);
    check("tx count", ntx, u_br.txq.size());
    check("access count", nacc, accq.size());
  endtask

  task automatic t_write;
    send('{8'h00, 8'h81, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h02,
           8'h12, 8'h34, 8'hab, 8'hcd});
    run(0, 2);
    check("write 0", {2'h0, 1'b1, 5'h03, 16'h1234}, accq[0]);
    check("write 1", {2'h0, 1'b1, 5'h04, 16'habcd}, accq[1]);
  endtask

  task automatic t_read;
    slow = 1'b1;
    send('{8'h00, 8'h01, 8'h00, 8'h00, 8'h1e, 8'h00, 8'h00, 8'h02});
    run(4, 2);
    check("read reg 0", 6'h1e, accq[0][21:16]);
    check("read reg 1", 6'h1f, accq[1][21:16]);
    foreach (u_br.txq[i])
      check("read byte", (i % 2) ? 8'h1e + i / 2 : 8'hc3, u_br.txq[i]);
    slow = 1'b0;
  endtask

  task automatic t_miss;
    send('{8'h00, 8'h90, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h01, 8'h55, 8'h66,
           8'h00, 8'h10, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h01,
           8'h00, 8'h01, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00,
           8'h00, 8'h81, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00,
           8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01,
           8'h00, 8'h81, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h01, 8'h9a, 8'hbc});
    run(4, 1);
    check("miss data", 16'h0000, {u_br.txq[0], u_br.txq[1]});
    check("window miss", 16'h0000, {u_br.txq[2], u_br.txq[3]});
    check("aligned", {2'h0, 1'b1, 5'h07, 16'h9abc}, accq[0]);
  endtask

  // Forty words from register zero: only the controller window lands
  task automatic t_burst;
    logic [7:0] b[$];
    b = '{8'h00, 8'h81, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h28};
    for (int i = 0; i < 40; i++) begin
      b.push_back(i[7:0]);
      b.push_back(~i[7:0]);
    end
    send(b);
    run(0, 32);
    for (int i = 0; i < 32; i++)
      check("burst", {2'h0, 1'b1, i[4:0], i[7:0], ~i[7:0]}, accq[i]);
  endtask

  task automatic t_switch;
    logic [7:0] v[4] = '{8'h00, 8'h41, 8'hc2, 8'h84};
    foreach (v[i]) begin
      #1 board_config_switch_i = v[i];
      repeat (2) @(posedge clk_i);
      #1;
      check("switch", v[i], cfg_sw_o);
      check("role", {v[i][6], v[i][6] & ~v[i][7], v[i][6] & v[i][7]},
            {cfg_stacked_o, cfg_master_o, cfg_slave_o});
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #(40 * 20000);
    fail_count++;
    summarize();
  end

  initial begin
    repeat (2) @(posedge clk_i);
    check("reset pins", 5'h1c,
          {usb_oe_n_o, usb_rd_n_o, usb_wr_n_o, usb_data_oe_o, ctl_strobe_o});
    #1 rst_n_i = 1'b1;
    t_write();
    t_read();
    t_miss();
    t_burst();
    t_switch();
    summarize();
  end
endmodule
